// >>> design/ucsc_ctrl.v
/*
 * Charge scheme controller: mode decode, automatic charger state machine,
 * data-line switch gating, output discharge and HID wake detection.
 * Assumes analog bias drivers, current comparators and a power switch
 * outside; all pins other than clock and rstn are asynchronous.
 */
// Behaviour
// - Low scheme: positive 2.0V, negative 2.7V
// - Mid scheme swaps low-scheme bias levels
// - High scheme: both lines at 2.7V
// - Pull-up 1.2V briefly, then shorted mode
// - Automatic mode starts in low scheme
// - BC1.2 attach: discharge, power on, pull-up, short
// - Shorted until line released, then low scheme
// - Low-scheme device keeps low scheme
// - Above 900mA go mid, confirm charging
// - Above 1.8A go high scheme
// - Keep higher scheme while above 900mA, low after 500ms below
// - Forced modes hold one scheme only
// - Switches close in port modes with permit
// - Charging port keeps switches closed during handshake
// - Open on permit low, pins low, dedicated
// - Switches open throughout output discharge
// - Clear holds initial discharging state
// - Discharge: switch off, then back on
// - HID detected: ignore changes to 011
// - Classify low-speed and full-speed idle lines
// - Full speed needs 11s without positive drop
// - After wake, accept pin changes freely
// - Follow mode pins except HID override
// - No discharge between 1111 and 1110
`timescale 1ns/1ps
`include "ucsc_defs.vh"

module ucsc_ctrl #(
    parameter [31:0] PULLUP_CYC = `UCSC_PULLUP_CYC,
    parameter [31:0] CONFIRM_CYC = `UCSC_CONFIRM_CYC,
    parameter [31:0] DISCH_CYC = `UCSC_DISCH_CYC,
    parameter [31:0] FS_CYC = `UCSC_FS_CYC
) (
    input wire clock,
    input wire rstn,
    input wire mode_pin_a,
    input wire mode_pin_b,
    input wire mode_pin_c,
    input wire current_threshold_choice,
    input wire switch_permit,
    input wire dp_high,
    input wire dm_high,
    input wire bc12_attach,
    input wire over_900ma,
    input wire over_1800ma,
    output reg [2:0] bias_sel_q,
    output reg power_on_q,
    output reg discharge_q,
    output reg data_switch_q,
    output reg hid_detected_q
);

// ----------------------------------------
// Input synchronisers
// ----------------------------------------
reg [9:0] sync1_q;
reg [9:0] sync2_q;
always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
        sync1_q <= 10'h000;
        sync2_q <= 10'h000;
    end else begin
        sync1_q <= {mode_pin_a, mode_pin_b, mode_pin_c,
                    current_threshold_choice, switch_permit, dp_high,
                    dm_high, bc12_attach, over_900ma, over_1800ma};
        sync2_q <= sync1_q;
    end
end
wire [3:0] pins = sync2_q[9:6];
wire permit = sync2_q[5];
wire dp = sync2_q[4];
wire dm = sync2_q[3];
wire attach = sync2_q[2];
wire i900 = sync2_q[1];
wire i1800 = sync2_q[0];

// ----------------------------------------
// Mode decode
// ----------------------------------------
localparam [2:0] M_DISCH = 3'h0;
localparam [2:0] M_AUTO = 3'h1;
localparam [2:0] M_SDP = 3'h2;
localparam [2:0] M_SHORT = 3'h3;
localparam [2:0] M_DIV = 3'h4;
localparam [2:0] M_CDP = 3'h5;

function [2:0] mode_of;
    input [3:0] p;
    begin
        case (p[3:1])
            3'h0: mode_of = M_DISCH;
            3'h1: mode_of = M_AUTO;
            3'h2: mode_of = M_SDP;
            3'h3: mode_of = M_AUTO;
            3'h4: mode_of = M_SHORT;
            3'h5: mode_of = M_DIV;
            3'h6: mode_of = M_SDP;
            default: mode_of = p[0] ? M_CDP : M_SDP;
        endcase
    end
endfunction

function is_port;
    input [2:0] m;
    begin
        is_port = (m == M_SDP) || (m == M_CDP);
    end
endfunction

// ----------------------------------------
// Mode tracking with HID override
// ----------------------------------------
reg [3:0] pins_q;
reg [2:0] mode_q;
reg init_q;
wire [2:0] new_mode = mode_of(pins);
wire to_011 = (pins[3:1] == 3'h3);
wire from_wake = (pins_q[3:1] == 3'h7) || (pins_q[3:1] == 3'h6) ||
                 (pins_q[3:1] == 3'h2);
wire hold = hid_detected_q && to_011 && from_wake;
wire pins_chg = (pins != pins_q) && !hold;
wire cdp_pair = (pins[3:1] == 3'h7) && (pins_q[3:1] == 3'h7);

// ----------------------------------------
// Charger state machine
// ----------------------------------------
localparam [2:0] S_INIT = 3'h0;
localparam [2:0] S_LOW = 3'h1;
localparam [2:0] S_MID = 3'h2;
localparam [2:0] S_HIGH = 3'h3;
localparam [2:0] S_DISCH = 3'h4;
localparam [2:0] S_PULL = 3'h5;
localparam [2:0] S_SHORT = 3'h6;
localparam [2:0] S_FIXED = 3'h7;

reg [2:0] st_q;
reg [2:0] after_q;
reg [31:0] cnt_q;
reg [63:0] fs_cnt_q;
reg fs_cand_q;
reg dp_dropped_q;

// Port output off and discharging in these states
function in_disch;
    input [2:0] s;
    begin
        in_disch = (s == S_DISCH) || (s == S_INIT);
    end
endfunction

always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
        st_q <= S_INIT;
        after_q <= S_LOW;
        cnt_q <= 32'h00000000;
        pins_q <= 4'h0;
        mode_q <= M_DISCH;
        init_q <= 1'b1;
    end else if (init_q || pins_chg) begin
        init_q <= 1'b0;
        pins_q <= pins;
        mode_q <= new_mode;
        cnt_q <= 32'h00000000;
        if (init_q || !cdp_pair) begin
            st_q <= S_DISCH;
            after_q <= (new_mode == M_AUTO) ? S_LOW : S_FIXED;
        end
    end else begin
        case (st_q)
            S_DISCH: begin
                if (mode_q == M_DISCH) begin
                    cnt_q <= 32'h00000000;
                end else if (cnt_q >= DISCH_CYC - 32'h1) begin
                    cnt_q <= 32'h00000000;
                    st_q <= after_q;
                end else begin
                    cnt_q <= cnt_q + 32'h1;
                end
            end
            S_LOW: begin
                cnt_q <= 32'h00000000;
                if (attach) begin
                    st_q <= S_DISCH;
                    after_q <= S_PULL;
                end else if (i1800) begin
                    st_q <= S_HIGH;
                end else if (i900) begin
                    st_q <= S_MID;
                end
            end
            S_MID, S_HIGH: begin
                if (i1800 && st_q == S_MID) begin
                    st_q <= S_HIGH;
                    cnt_q <= 32'h00000000;
                end else if (i900) begin
                    cnt_q <= 32'h00000000;
                end else if (cnt_q >= CONFIRM_CYC - 32'h1) begin
                    st_q <= S_LOW;
                    cnt_q <= 32'h00000000;
                end else begin
                    cnt_q <= cnt_q + 32'h1;
                end
            end
            S_PULL: begin
                if (cnt_q >= PULLUP_CYC - 32'h1) begin
                    st_q <= S_SHORT;
                    cnt_q <= 32'h00000000;
                end else begin
                    cnt_q <= cnt_q + 32'h1;
                end
            end
            S_SHORT: begin
                if (!attach) begin
                    st_q <= S_LOW;
                end
            end
            S_FIXED: begin
                cnt_q <= 32'h00000000;
            end
            default: begin
                st_q <= S_DISCH;
            end
        endcase
    end
end

// ----------------------------------------
// HID detection
// ----------------------------------------
always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
        fs_cnt_q <= 64'h0;
        fs_cand_q <= 1'b0;
        dp_dropped_q <= 1'b0;
        hid_detected_q <= 1'b0;
    end else if (!is_port(mode_q) || st_q != S_FIXED) begin
        fs_cnt_q <= 64'h0;
        fs_cand_q <= 1'b0;
        dp_dropped_q <= 1'b0;
        if (!(hold || mode_q == M_AUTO)) begin
            hid_detected_q <= 1'b0;
        end
    end else if (dm && !dp) begin
        hid_detected_q <= 1'b1;
    end else if (dp && !dm) begin
        fs_cand_q <= 1'b1;
        if (!dp_dropped_q && fs_cnt_q >= FS_CYC - 64'h1) begin
            hid_detected_q <= 1'b1;
        end else begin
            fs_cnt_q <= fs_cnt_q + 64'h1;
        end
    end else if (fs_cand_q && !dp) begin
        dp_dropped_q <= 1'b1;
        hid_detected_q <= 1'b0;
    end else if (!dp && !dm) begin
        fs_cnt_q <= 64'h0;
        fs_cand_q <= 1'b0;
        dp_dropped_q <= 1'b0;
        hid_detected_q <= 1'b0;
    end
end

// ----------------------------------------
// Outputs
// ----------------------------------------
always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
        bias_sel_q <= `UCSC_BIAS_OPEN;
        power_on_q <= 1'b0;
        discharge_q <= 1'b1;
        data_switch_q <= 1'b0;
    end else begin
        power_on_q <= !in_disch(st_q);
        discharge_q <= in_disch(st_q);
        data_switch_q <= permit && is_port(mode_q) &&
                         (st_q == S_FIXED);
        case (st_q)
            S_LOW: bias_sel_q <= `UCSC_BIAS_LOW;
            S_MID: bias_sel_q <= `UCSC_BIAS_MID;
            S_HIGH: bias_sel_q <= `UCSC_BIAS_HIGH;
            S_PULL: bias_sel_q <= `UCSC_BIAS_PULLUP;
            S_SHORT: bias_sel_q <= `UCSC_BIAS_SHORT;
            S_FIXED: begin
                if (mode_q == M_SHORT) begin
                    bias_sel_q <= `UCSC_BIAS_SHORT;
                end else if (mode_q == M_DIV) begin
                    bias_sel_q <= `UCSC_BIAS_LOW;
                end else begin
                    bias_sel_q <= `UCSC_BIAS_OPEN;
                end
            end
            default: bias_sel_q <= `UCSC_BIAS_OPEN;
        endcase
    end
end

endmodule // ucsc_ctrl

// >>> design/ucsc_defs.vh
/*
 * Constants for the charge scheme controller: clock, bias codes, timing.
 * Assumes a 200 MHz core clock; included by the controller only.
 */
`ifndef UCSC_DEFS_VH
`define UCSC_DEFS_VH

`define UCSC_CLK_MHZ 200
// Bias select codes to the analog data-line drivers
`define UCSC_BIAS_OPEN 3'h0
`define UCSC_BIAS_LOW 3'h1
`define UCSC_BIAS_MID 3'h2
`define UCSC_BIAS_HIGH 3'h3
`define UCSC_BIAS_PULLUP 3'h4
`define UCSC_BIAS_SHORT 3'h5
// Brief pull-up interval, ms
`define UCSC_PULLUP_MS 100
// High-current confirmation interval, ms
`define UCSC_CONFIRM_MS 500
// Output discharge interval, ms
`define UCSC_DISCH_MS 200
// Full-speed recognition interval, s
`define UCSC_FS_SEC 11
`define UCSC_PULLUP_CYC (`UCSC_PULLUP_MS * 1000 * `UCSC_CLK_MHZ)
`define UCSC_CONFIRM_CYC (`UCSC_CONFIRM_MS * 1000 * `UCSC_CLK_MHZ)
`define UCSC_DISCH_CYC (`UCSC_DISCH_MS * 1000 * `UCSC_CLK_MHZ)
// Kept at 32 bits: the count fits, the cycle parameters are 32 wide
`define UCSC_FS_CYC (32'h000F4240 * `UCSC_FS_SEC * `UCSC_CLK_MHZ)

`endif

// >>> tb/ucsc_ctrl_sva.sv
/* Port checker for the charge scheme controller.
   Bound to every controller instance; one clock domain. */
`timescale 1ns/1ps
module ucsc_ctrl_sva (
    input wire clock,
    input wire rstn,
    input wire mode_pin_a,
    input wire mode_pin_b,
    input wire mode_pin_c,
    input wire switch_permit,
    input wire dp_high,
    input wire dm_high,
    input wire bc12_attach,
    input wire [2:0] bias_sel_q,
    input wire power_on_q,
    input wire discharge_q,
    input wire data_switch_q,
    input wire hid_detected_q
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    wire auto_w = !mode_pin_a && mode_pin_c && !bc12_attach;
    wire short_w = mode_pin_a && !mode_pin_b && !mode_pin_c;
    a_disch_switch_open: assert property (
        discharge_q |-> !data_switch_q) else $error("switch closed");
    a_disch_power_off: assert property (
        discharge_q |-> !power_on_q) else $error("power on in discharge");
    a_permit_open: assert property (
        !switch_permit [*6] |-> !data_switch_q) else $error("no permit");
    a_pullup_exit: assert property (
        $fell(bias_sel_q == 3'h4) |-> bias_sel_q == 3'h5 || discharge_q)
        else $error("pull-up exit");
    a_power_restore: assert property (
        $fell(discharge_q) |-> ##[0:1] power_on_q) else $error("no power");
    a_ls_hid_seen: assert property (
        (data_switch_q && dm_high && !dp_high) [*6] |-> hid_detected_q)
        else $error("hid missed");
    a_auto_low_start: assert property (
        auto_w [*6] ##1 $fell(discharge_q) |-> ##[0:1] bias_sel_q == 3'h1)
        else $error("auto start");
    a_forced_short: assert property (
        short_w [*6] ##0 (!discharge_q) [*2] |-> bias_sel_q == 3'h5)
        else $error("forced short");
endmodule // ucsc_ctrl_sva

bind ucsc_ctrl ucsc_ctrl_sva chk_u (.clock, .rstn, .mode_pin_a,
    .mode_pin_b, .mode_pin_c, .switch_permit, .dp_high, .dm_high,
    .bc12_attach, .bias_sel_q, .power_on_q, .discharge_q,
    .data_switch_q, .hid_detected_q);

// >>> tb/ucsc_port_dev.sv
/* Portable device model on the charging port.
   Kind picks the device; rel makes a BC1.2 device let go. */
`timescale 1ns/1ps
module ucsc_port_dev (
    input wire [2:0] kind,
    input wire rel,
    input wire [2:0] bias_sel_q,
    input wire power_on_q,
    output wire dp_high,
    output wire dm_high,
    output wire bc12_attach,
    output wire over_900ma,
    output wire over_1800ma
);
    // Kinds: 1 BC1.2, 2 mid load, 3 LS HID, 4 FS HID, 5 high load
    wire load_w = power_on_q && bias_sel_q != 3'h0;
    assign dm_high = kind == 3'h3;
    assign dp_high = kind == 3'h4;
    assign bc12_attach = kind == 3'h1 && !rel;
    assign over_900ma = load_w && (kind == 3'h2 || kind == 3'h5);
    assign over_1800ma = load_w && kind == 3'h5;
endmodule // ucsc_port_dev

// >>> tb/ucsc_ctrl_tb.sv
/* Bench for the charge scheme controller with a device model.
   Short counts: discharge and pull-up 20, confirm 50, FS 100. */
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
    error_cnt++; \
    $display("wrong value %0t: got %h want %h", $time, a, b); end end
`define WAIT(c) begin n = 0; while (!(c) && n < 400) begin tick(1); \
    n++; end if (n >= 400) begin error_cnt++; complete_run; end end
module ucsc_ctrl_tb;
    reg clock = 0, rstn = 0, sp = 0, rel = 0;
    reg [3:0] pins = 4'h0;
    reg [2:0] kind = 3'h0;
    wire dp_high, dm_high, bc12_attach, over_900ma, over_1800ma;
    wire [2:0] bias_sel_q;
    wire power_on_q, discharge_q, data_switch_q, hid_detected_q;
    integer error_cnt = 0, samples_checked = 0, n, i;
    initial forever #2.5 clock = ~clock;
    ucsc_ctrl #(.PULLUP_CYC(20), .CONFIRM_CYC(50), .DISCH_CYC(20),
        .FS_CYC(100)) dut_u (.clock, .rstn, .mode_pin_a(pins[3]),
        .mode_pin_b(pins[2]), .mode_pin_c(pins[1]),
        .current_threshold_choice(pins[0]), .switch_permit(sp),
        .dp_high, .dm_high, .bc12_attach, .over_900ma, .over_1800ma,
        .bias_sel_q, .power_on_q, .discharge_q, .data_switch_q,
        .hid_detected_q);
    ucsc_port_dev dev_u (.kind, .rel, .bias_sel_q, .power_on_q,
        .dp_high, .dm_high, .bc12_attach, .over_900ma, .over_1800ma);
    task tick(input integer k);
        repeat (k) @(posedge clock);
        #1;
    endtask
    task complete_run;
        if (error_cnt == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task do_reset;
        rstn = 0;
        tick(20);
        `CHK({discharge_q, bias_sel_q, power_on_q}, 5'h10)
        `CHK({data_switch_q, hid_detected_q}, 2'b00)
        rstn = 1;
    endtask
    task set_mode(input [3:0] p);
        pins = p;
        `WAIT(discharge_q === 1'b1)
        `WAIT(discharge_q === 1'b0)
        tick(2);
    endtask
    initial begin
        do_reset;
        tick(40);
        `CHK({discharge_q, data_switch_q}, 2'b10)
        sp = 1;
        set_mode(4'h4);
        `CHK({data_switch_q, power_on_q}, 2'b11)
        sp = 0;
        tick(6);
        `CHK(data_switch_q, 1'b0)
        sp = 1;
        kind = 3'h3;
        tick(6);
        `CHK({hid_detected_q, data_switch_q}, 2'b11)
        pins = 4'h6;
        tick(30);
        `CHK({discharge_q, data_switch_q}, 2'b01)
        kind = 3'h0;
        do_reset;
        set_mode(4'hC);
        kind = 3'h4;
        tick(60);
        `CHK(hid_detected_q, 1'b0)
        tick(50);
        `CHK(hid_detected_q, 1'b1)
        pins = 4'hE;
        tick(8);
        `CHK(discharge_q, 1'b1)
        `WAIT(discharge_q === 1'b0)
        tick(2);
        kind = 3'h0;
        pins = 4'hF;
        for (i = 0; i < 12; i++) begin
            tick(1);
            `CHK({discharge_q, data_switch_q}, 2'b01)
        end
        kind = 3'h4;
        tick(30);
        kind = 3'h0;
        tick(5);
        kind = 3'h4;
        tick(110);
        `CHK(hid_detected_q, 1'b0)
        kind = 3'h0;
        do_reset;
        set_mode(4'h2);
        `CHK(bias_sel_q, 3'h1)
        kind = 3'h5;
        tick(6);
        `CHK(bias_sel_q, 3'h3)
        kind = 3'h2;
        tick(40);
        `CHK(bias_sel_q, 3'h3)
        kind = 3'h0;
        tick(40);
        `CHK(bias_sel_q, 3'h3)
        tick(20);
        `CHK(bias_sel_q, 3'h1)
        kind = 3'h2;
        tick(6);
        `CHK(bias_sel_q, 3'h2)
        kind = 3'h0;
        tick(60);
        `CHK(bias_sel_q, 3'h1)
        kind = 3'h1;
        `WAIT(discharge_q === 1'b1)
        `CHK({power_on_q, data_switch_q}, 2'b00)
        `WAIT(bias_sel_q === 3'h4)
        `CHK({power_on_q, discharge_q}, 2'b10)
        tick(10);
        `WAIT(bias_sel_q === 3'h5)
        `CHK(n >= 8 && n <= 12, 1'b1)
        tick(30);
        `CHK(bias_sel_q, 3'h5)
        rel = 1;
        tick(6);
        `CHK(bias_sel_q, 3'h1)
        kind = 3'h2;
        set_mode(4'h8);
        `CHK({bias_sel_q, data_switch_q}, 4'hA)
        set_mode(4'hA);
        tick(30);
        `CHK({bias_sel_q, data_switch_q}, 4'h2)
        kind = 3'h0;
        set_mode(4'h6);
        `CHK(bias_sel_q, 3'h1)
        complete_run;
    end
endmodule // ucsc_ctrl_tb
